// ### clock_generator_cfg.svh
/*
 register offsets, field positions, reset values and timing counts of the
 clock generator; assumes byte addresses on the peripheral register port.
*/
`ifndef CLOCK_GENERATOR_CFG_SVH
`define CLOCK_GENERATOR_CFG_SVH

// byte offsets of the three control registers
`define PERIPH_DIV_OFFSET   12'h244
`define PROC_DIV_OFFSET     12'h248
`define MISC_CTRL_OFFSET    12'h24c

// reset values
`define PERIPH_DIV_RESET    8'h00
`define PROC_DIV_RESET      8'h00
`define MISC_CTRL_RESET     8'h00

// divider register fields
`define DIV_LOW_LSB         0
`define DIV_LOW_MSB         3
`define DIV_HIGH_LSB        4
`define DIV_HIGH_MSB        7
`define DIV_STOP_PATTERN    4'h9

// miscellaneous register fields
`define MISC_DPLL_BIT       0
`define MISC_UART_OFF_BIT   1
`define MISC_BUS_SEL_LSB    2
`define MISC_BUS_SEL_MSB    3

// uart reference: input * 6 / 25 gives 15.36 MHz -> 3.6864 MHz
`define UART_RATE_STEP      5'h06
`define UART_RATE_MODULUS   5'h19

`endif

// ### clock_generator_pkg.sv
/*
 types of the clock generator: register request carrier and processor
 clock state; assumes clock_generator_cfg.svh holds the numbers.
*/
package clock_generator_pkg;

   // one register access from the processor side
   typedef struct packed {
      logic        write;
      logic        read;
      logic [11:0] addr;
      logic [7:0]  wdata;
   } reg_req_t;

   // processor clock state, one-hot
   typedef enum logic [1:0] {
      PROC_RUNNING = 2'b01,
      PROC_STOPPED = 2'b10
   } proc_state_t;

endpackage : clock_generator_pkg

// ### clock_divider_cell.sv
/*
 one programmable even divider: input / (2 * n), n = 0 meaning /1 on tick and /2 on level.
 assumes a synchronous enable from the register logic on the same clock.
*/
`timescale 1ns/1ps

module clock_divider_cell (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic [3:0] divisor,
   input  wire logic       enable,
   output logic            tick,
   output logic            level
);

   logic [4:0] count;
   logic [3:0] active_div;
   logic [4:0] next_count;
   logic [3:0] next_active_div;
   logic       next_tick;
   logic       next_level;
   logic [4:0] period_end;

   // new divisor only loaded at a period boundary, so no runt pulses
   always_comb begin
      period_end      = {active_div, 1'b0} - 5'h01;
      next_count      = count;
      next_active_div = active_div;
      next_tick       = 1'b0;
      next_level      = level;
      if (!enable) begin
         next_count      = 5'h00;
         next_active_div = divisor;
         next_level      = 1'b1;
      end else if (active_div == 4'h0) begin
         next_tick       = 1'b1;
         next_level      = ~level;                    // fastest a flop can toggle
         next_active_div = divisor;
      end else begin
         if (count == period_end) begin
            next_count      = 5'h00;
            next_active_div = divisor;
         end else begin
            next_count = count + 5'h01;
         end
         next_tick  = (next_count == 5'h00);
         next_level = (next_count < {1'b0, active_div});
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         count      <= 5'h00;
         active_div <= 4'h0;
         tick       <= 1'b0;
         level      <= 1'b1;
      end else begin
         count      <= next_count;
         active_div <= next_active_div;
         tick       <= next_tick;
         level      <= next_level;
      end
   end

endmodule : clock_divider_cell

// ### clock_generator.sv
/*
 clock generator: peripheral clock pin, processor clock enable with stop and
 wake, uart reference enable, peripheral-bus clock enable, three byte
 registers. assumes core_clk is the master input clock and that all
 request inputs come from logic on the same clock.
*/
// How it works
// - while processor clock stopped, an enabled interrupt restarts it and raises the interrupt.
// - waking clears the upper nibble of the processor divider register.
// - stopping the processor clock leaves uart, bus and peripheral clocks running.
// - both divider registers reset to zero: enabled, processor undivided, peripheral at input over two.
// - a fixed uart reference of 3.6864 MHz comes from the input clock.
// - peripheral clock is input over twice the low nibble; zero gives input over two.
// - upper nibble 1001 disables the peripheral clock output.
// - processor clock is input over twice the low nibble; zero means one.
// - upper nibble 1001 stops the processor clock completely.
// - misc bit 0 is read-only dpll lock status.
// - misc bit 1 disables the uart reference clock.
// - misc bits 3:2 select bus clock as input over 4, 8, 16, 32.
// - a disabled peripheral clock output stays high.
// - the stopping write's low nibble sets the processor restart frequency.
`timescale 1ns/1ps
`include "clock_generator_cfg.svh"

module clock_generator (
   input  wire logic                        core_clk,
   input  wire logic                        rst,
   input  wire clock_generator_pkg::reg_req_t reg_req,
   input  wire logic                        dpll_locked,
   input  wire logic                        fast_int_source,
   input  wire logic                        normal_int_source,
   output logic [7:0]                       reg_rdata,
   output logic                             peripheral_clock_output,
   output logic                             processor_clock_enable,
   output logic                             processor_stopped,
   output logic                             fast_interrupt_request,
   output logic                             normal_interrupt_request,
   output logic                             uart_clock_enable,
   output logic                             bus_clock_enable
);
   import clock_generator_pkg::*;

   logic [7:0]  periph_div;
   logic [7:0]  proc_div;
   logic [3:2]  bus_sel;
   logic        uart_off;
   proc_state_t proc_state;
   logic [7:0]  next_periph_div;
   logic [7:0]  next_proc_div;
   logic [3:2]  next_bus_sel;
   logic        next_uart_off;
   proc_state_t next_proc_state;
   logic [7:0]  next_rdata;
   logic        wake;
   logic        periph_enable;
   logic        proc_enable;
   logic        periph_tick;
   logic        periph_level;
   logic        proc_tick;
   logic        proc_level;

   // any enabled interrupt source wakes a stopped processor
   assign wake          = (proc_state == PROC_STOPPED)
                          && (fast_int_source || normal_int_source);
   assign periph_enable = (periph_div[`DIV_HIGH_MSB:`DIV_HIGH_LSB]
                           != `DIV_STOP_PATTERN);
   assign proc_enable   = (proc_state == PROC_RUNNING);

   // register writes, stop detection and wake clear
   always_comb begin
      next_periph_div = periph_div;
      next_proc_div   = proc_div;
      next_bus_sel    = bus_sel;
      next_uart_off   = uart_off;
      next_proc_state = proc_state;
      if (reg_req.write) begin
         case (reg_req.addr)
            `PERIPH_DIV_OFFSET: next_periph_div = reg_req.wdata;
            `PROC_DIV_OFFSET:   next_proc_div   = reg_req.wdata;
            `MISC_CTRL_OFFSET: begin
               next_uart_off = reg_req.wdata[`MISC_UART_OFF_BIT];
               next_bus_sel  = reg_req.wdata[`MISC_BUS_SEL_MSB:`MISC_BUS_SEL_LSB];
            end
            default: ;
         endcase
      end
      // hardware wake beats a same-cycle write so the processor never stays dead
      if (wake) begin
         next_proc_div[`DIV_HIGH_MSB:`DIV_HIGH_LSB] = 4'h0;
      end
      case (proc_state)
         PROC_RUNNING: begin
            if (next_proc_div[`DIV_HIGH_MSB:`DIV_HIGH_LSB] == `DIV_STOP_PATTERN)
               next_proc_state = PROC_STOPPED;
         end
         PROC_STOPPED: begin
            if (wake || next_proc_div[`DIV_HIGH_MSB:`DIV_HIGH_LSB] != `DIV_STOP_PATTERN)
               next_proc_state = PROC_RUNNING;
         end
         default: next_proc_state = PROC_RUNNING;
      endcase
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      next_rdata = reg_rdata;
      if (reg_req.read) begin
         case (reg_req.addr)
            `PERIPH_DIV_OFFSET: next_rdata = periph_div;
            `PROC_DIV_OFFSET:   next_rdata = proc_div;
            `MISC_CTRL_OFFSET:  next_rdata = {4'h0, bus_sel, uart_off,
                                              dpll_locked};
            default:            next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         periph_div <= `PERIPH_DIV_RESET;
         proc_div   <= `PROC_DIV_RESET;
         bus_sel    <= 2'(`MISC_CTRL_RESET >> `MISC_BUS_SEL_LSB);
         uart_off   <= 1'b0;
         proc_state <= PROC_RUNNING;
         reg_rdata  <= 8'h00;
      end else begin
         periph_div <= next_periph_div;
         proc_div   <= next_proc_div;
         bus_sel    <= next_bus_sel;
         uart_off   <= next_uart_off;
         proc_state <= next_proc_state;
         reg_rdata  <= next_rdata;
      end
   end

   // peripheral clock pin divider; fed the next value so a re-enabling write
   // restarts at the nibble written with it, not the stale one
   clock_divider_cell periph_divider (
      .core_clk (core_clk),
      .rst      (rst),
      .divisor  (next_periph_div[`DIV_LOW_MSB:`DIV_LOW_LSB]),
      .enable   (periph_enable),
      .tick     (periph_tick),
      .level    (periph_level)
   );

   // processor clock divider; restart rate is whatever low nibble holds
   clock_divider_cell proc_divider (
      .core_clk (core_clk),
      .rst      (rst),
      .divisor  (next_proc_div[`DIV_LOW_MSB:`DIV_LOW_LSB]),
      .enable   (proc_enable),
      .tick     (proc_tick),
      .level    (proc_level)
   );

   // uart and bus clocks, independent of processor stop
   logic [4:0] uart_phase;
   logic [4:0] bus_count;
   logic [4:0] next_uart_phase;
   logic [4:0] next_bus_count;
   logic       next_uart_enable;
   logic       next_bus_enable;
   logic [4:0] uart_sum;
   logic [4:0] bus_mask;

   always_comb begin
      // fractional accumulator: 6 ticks per 25 input cycles, no pll needed
      uart_sum         = uart_phase + `UART_RATE_STEP;
      next_uart_phase  = uart_phase;
      next_uart_enable = 1'b0;
      if (!uart_off) begin
         if (uart_sum >= `UART_RATE_MODULUS) begin
            next_uart_phase  = uart_sum - `UART_RATE_MODULUS;
            next_uart_enable = 1'b1;
         end else begin
            next_uart_phase = uart_sum;
         end
      end
      case (bus_sel)
         2'h0:    bus_mask = 5'h03;
         2'h1:    bus_mask = 5'h07;
         2'h2:    bus_mask = 5'h0f;
         default: bus_mask = 5'h1f;
      endcase
      next_bus_count  = bus_count + 5'h01;
      next_bus_enable = ((bus_count & bus_mask) == bus_mask);
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         uart_phase               <= 5'h00;
         bus_count                <= 5'h00;
         uart_clock_enable        <= 1'b0;
         bus_clock_enable         <= 1'b0;
         peripheral_clock_output  <= 1'b1;
         processor_clock_enable   <= 1'b0;
         processor_stopped        <= 1'b0;
         fast_interrupt_request   <= 1'b0;
         normal_interrupt_request <= 1'b0;
      end else begin
         uart_phase               <= next_uart_phase;
         bus_count                <= next_bus_count;
         uart_clock_enable        <= next_uart_enable;
         bus_clock_enable         <= next_bus_enable;
         peripheral_clock_output  <= periph_level;
         // gated by state so no tick leaks out once stopped shows high
         processor_clock_enable   <= proc_tick && proc_enable;
         processor_stopped        <= (proc_state == PROC_STOPPED);
         fast_interrupt_request   <= fast_int_source;
         normal_interrupt_request <= normal_int_source;
      end
   end

   // processor divider level is left unused; tick is what the core uses
   logic unused_proc_level;
   assign unused_proc_level = proc_level & periph_tick;

endmodule : clock_generator

// ### clock_generator_assertions.sv
/* port checker of clock_generator; assumes it is bound into that module. */
`timescale 1ns/1ps
module clock_generator_checker (
   input wire logic                          core_clk,
   input wire logic                          rst,
   input wire clock_generator_pkg::reg_req_t reg_req,
   input wire logic                          dpll_locked,
   input wire logic                          fast_int_source,
   input wire logic                          normal_int_source,
   input wire logic [7:0]                    reg_rdata,
   input wire logic                          peripheral_clock_output,
   input wire logic                          processor_clock_enable,
   input wire logic                          processor_stopped,
   input wire logic                          normal_interrupt_request,
   input wire logic                          uart_clock_enable,
   input wire logic                          bus_clock_enable
);
   import clock_generator_pkg::*;
   logic wake;
   logic stop_wr;
   logic park_wr;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // a pending wake would beat the stop write, so leave it out
   assign wake    = fast_int_source || normal_int_source;
   assign stop_wr = reg_req.write && reg_req.addr == 12'h248
                    && reg_req.wdata[7:4] == 4'h9 && !wake;
   assign park_wr = reg_req.write && reg_req.addr == 12'h244 && reg_req.wdata[7:4] == 4'h9;
   stop_enter_a: assert property (stop_wr |-> ##2 processor_stopped)
      else $error("processor clock did not stop");
   stopped_quiet_a: assert property (processor_stopped |-> !processor_clock_enable)
      else $error("processor enable pulse while stopped");
   wake_restart_a: assert property (processor_stopped && wake |-> ##2 !processor_stopped)
      else $error("wake source did not restart processor clock");
   irq_mirror_a: assert property (normal_int_source |=> normal_interrupt_request)
      else $error("normal interrupt not raised");
   pin_parked_a: assert property (park_wr |-> ##2 peripheral_clock_output [*4])
      else $error("disabled pin not held high");
   lock_read_a: assert property (reg_req.read && reg_req.addr == 12'h24c
      |-> ##2 reg_rdata[0] == $past(dpll_locked, 2))
      else $error("lock status bit wrong");
   bus_gap_a: assert property (bus_clock_enable |=> !bus_clock_enable [*3])
      else $error("bus enable faster than input over 4");
   uart_gap_a: assert property (uart_clock_enable |=> !uart_clock_enable)
      else $error("uart enable pulses adjacent");
   keep_running_a: assert property (processor_stopped |-> ##[0:32] bus_clock_enable)
      else $error("bus clock halted with processor");
   cover property (stop_wr);
   cover property (processor_stopped && wake);
   cover property (park_wr);
endmodule : clock_generator_checker
bind clock_generator clock_generator_checker chk (.core_clk, .rst, .reg_req, .dpll_locked,
   .fast_int_source, .normal_int_source, .reg_rdata, .peripheral_clock_output,
   .processor_clock_enable, .processor_stopped, .normal_interrupt_request,
   .uart_clock_enable, .bus_clock_enable);

// ### wake_source_model.sv
/* processor-side interrupt sources; assumes the bench asks for each wake. */
`timescale 1ns/1ps
module wake_source_model (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic raise_fast,
   input  wire logic raise_normal,
   input  wire logic fast_interrupt_request,
   input  wire logic normal_interrupt_request,
   output logic      fast_int_source,
   output logic      normal_int_source
);
   logic next_fast;
   logic next_normal;
   // sources are unmasked and held until the matching interrupt request is seen high
   always_comb begin
      next_fast   = (fast_int_source && !fast_interrupt_request) || raise_fast;
      next_normal = (normal_int_source && !normal_interrupt_request) || raise_normal;
   end
   // state registers
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         fast_int_source   <= 1'b0;
         normal_int_source <= 1'b0;
      end else begin
         fast_int_source   <= next_fast;
         normal_int_source <= next_normal;
      end
   end
endmodule : wake_source_model

// ### clock_generator_dividers_test.sv
/* self-checking bench of clock_generator; assumes the bound checker. */
`timescale 1ns/1ps
module clock_generator_dividers_test;
   import clock_generator_pkg::*;
   logic       core_clk, rst, dpll_locked, raise_fast, raise_normal;
   logic       fast_int_source, normal_int_source, peripheral_clock_output;
   logic       processor_clock_enable, processor_stopped, fast_interrupt_request;
   logic       normal_interrupt_request, uart_clock_enable, bus_clock_enable;
   logic [7:0] reg_rdata;
   reg_req_t   reg_req;
   int         errors, n_compared, cycles;
   clock_generator uut (.core_clk, .rst, .reg_req, .dpll_locked, .fast_int_source,
      .normal_int_source, .reg_rdata, .peripheral_clock_output, .processor_clock_enable,
      .processor_stopped, .fast_interrupt_request, .normal_interrupt_request,
      .uart_clock_enable, .bus_clock_enable);
   wake_source_model partner (.core_clk, .rst, .raise_fast, .raise_normal,
      .fast_interrupt_request, .normal_interrupt_request, .fast_int_source, .normal_int_source);
   // 40 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // hang guard, well above the sequence length
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         close_out();
      end
   end
   task automatic close_out();
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : close_out
   task automatic check(string what, logic [7:0] exp, logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic wr(logic [11:0] a, logic [7:0] d);
      @(posedge core_clk) #1;
      reg_req = '{1'b1, 1'b0, a, d};
      @(posedge core_clk) #1;
      reg_req.write = 1'b0;
   endtask : wr
   // read data holds, so one spare edge covers either update edge
   task automatic rd(logic [11:0] a, logic [7:0] exp);
      @(posedge core_clk) #1;
      reg_req = '{1'b0, 1'b1, a, 8'h00};
      @(posedge core_clk) #1;
      reg_req.read = 1'b0;
      @(posedge core_clk) #1;
      check("reg_rdata", exp, reg_rdata);
   endtask : rd
   // cycles between two rises of pin (0), processor enable (1) or bus enable (2)
   task automatic gap(int s, int exp, string what);
      int n, k, g;
      logic prev, cur;
      n = 0;
      k = 0;
      g = 0;
      prev = 1'b1;
      while (k < 2 && g < 300) begin
         @(posedge core_clk) #1;
         cur = s == 0 ? peripheral_clock_output
             : s == 1 ? processor_clock_enable : bus_clock_enable;
         g++;
         if (k == 1) n++;
         if (cur === 1'b1 && prev === 1'b0) k++;
         prev = cur;
      end
      check(what, 8'(exp), 8'(n));
   endtask : gap
   // uart pulses or high pin cycles over 100 cycles
   task automatic count(logic pin, int exp);
      int n;
      n = 0;
      repeat (100) begin
         @(posedge core_clk) #1;
         if ((pin ? peripheral_clock_output : uart_clock_enable) === 1'b1) n++;
      end
      check(pin ? "pin high" : "uart pulses", 8'(exp), 8'(n));
   endtask : count
   initial begin
      rst = 1'b1;
      reg_req = '0;
      dpll_locked = 1'b0;
      raise_fast = 1'b0;
      raise_normal = 1'b0;
      repeat (8) @(posedge core_clk);
      #1 rst = 1'b0;
      rd(12'h244, 8'h00);
      rd(12'h248, 8'h00);
      rd(12'h24c, 8'h00);
      rd(12'h250, 8'h00);
      dpll_locked = 1'b1;
      wr(12'h24c, 8'h0e);
      rd(12'h24c, 8'h0f);
      count(1'b0, 0);
      for (int c = 0; c < 4; c++) begin
         wr(12'h24c, 8'(c << 2));
         gap(2, 4 << c, "bus period");
      end
      count(1'b0, 24);
      for (int n = 1; n < 16; n += 7) begin
         wr(12'h244, 8'(n));
         gap(0, 2 * n, "pin period");
         wr(12'h248, 8'(n));
         gap(1, 2 * n, "cpu period");
      end
      wr(12'h244, 8'h93);
      repeat (2) @(posedge core_clk);
      count(1'b1, 100);
      wr(12'h244, 8'h52);
      gap(0, 4, "pin restart");
      // once per wake kind
      for (int k = 0; k < 2; k++) begin
         wr(12'h248, 8'h92);
         count(1'b0, 24);
         check("stopped", 8'h01, 8'(processor_stopped));
         raise_fast = k == 0;
         raise_normal = k == 1;
         @(posedge core_clk) #1;
         raise_fast = 1'b0;
         raise_normal = 1'b0;
         repeat (2) @(posedge core_clk) #1;
         check("irq", 8'h01, 8'(k ? normal_interrupt_request : fast_interrupt_request));
         rd(12'h248, 8'h02);
         gap(1, 4, "cpu restart");
      end
      close_out();
   end
endmodule : clock_generator_dividers_test
